// >>> verilog/pot_device.sv
`timescale 1ns/1ps
`default_nettype none

module pot_device (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  pot_link_if.device       link,
  input  wire logic        strap_addr_bit0_i,
  input  wire logic        strap_addr_bit1_i,
  input  wire logic        strap_addr_bit2_i,
  input  wire logic        nv_write_en_i,
  output logic [31:0]      wiper_pos_o
);

  localparam int unsigned SYNC_W = 10;

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [2:0]        prev_r;
  logic              scl_s;
  logic              sda_s;
  logic              cs_s;
  logic              dir_s;
  logic [1:0]        sel_s;
  logic              wp_s;
  logic [2:0]        strap_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              bus_start;
  logic              bus_stop;
  logic              ud_step;
  logic              ud_store;

  pot_pkg::dev_state_t state_r;
  logic [2:0]        bit_cnt_r;
  logic [1:0]        byte_idx_r;
  logic [7:0]        rx_r;
  logic [7:0]        instr_r;
  logic [7:0]        tx_r;
  logic              ack_ok_r;
  logic              ack_phase_r;
  logic              drive_low_r;
  logic              recall_r;

  logic [7:0]        rx_nxt;
  logic              byte_done;
  logic              bus_wr_wiper;
  logic              bus_wr_saved;
  logic [1:0]        ins_pot;
  logic [1:0]        ins_slot;
  logic [7:0]        rd_val;

  logic [7:0] wiper_position_reg_r [pot_pkg::NUM_POTS];
  logic [7:0] saved_position_reg_r [pot_pkg::NUM_POTS][pot_pkg::NUM_SAVED];

  // Two flops per pin; reset to idle link levels so no edge follows reset
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sync1_r <= 10'h007;
      sync2_r <= 10'h007;
      prev_r  <= 3'h7;
    end else begin
      sync1_r <= {strap_addr_bit2_i, strap_addr_bit1_i, strap_addr_bit0_i,
                  nv_write_en_i, link.pot_selector_hi,
                  link.pot_selector_lo, link.dir_up, link.cs_n,
                  link.sda, link.scl};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r[2:0];
    end
  end

  assign scl_s   = sync2_r[0];
  assign sda_s   = sync2_r[1];
  assign cs_s    = sync2_r[2];
  assign dir_s   = sync2_r[3];
  assign sel_s   = sync2_r[5:4];
  assign wp_s    = sync2_r[6];
  assign strap_s = sync2_r[9:7];

  // One clock pin drives both the bus and the counter
  assign scl_rise  = scl_s & ~prev_r[0];
  assign scl_fall  = ~scl_s & prev_r[0];
  assign bus_start = cs_s & scl_s & prev_r[0] & prev_r[1] & ~sda_s;
  assign bus_stop  = cs_s & scl_s & prev_r[0] & ~prev_r[1] & sda_s;

  // Select low counts on clock rises
  assign ud_step  = ~cs_s & scl_rise & ~recall_r;
  // Select released while clock high saves wiper into slot 0 if nv_write_en_i is high
  assign ud_store = cs_s & ~prev_r[2] & scl_s & wp_s & ~recall_r;

  assign rx_nxt    = {rx_r[6:0], sda_s};
  assign byte_done = (state_r == pot_pkg::DS_RECV) & scl_rise &
                     (bit_cnt_r == 3'd7);
  assign ins_pot   = instr_r[pot_pkg::INS_POT_LSB +: 2];
  assign ins_slot  = instr_r[pot_pkg::INS_SLOT_LSB +: 2];
  assign bus_wr_wiper = byte_done & (byte_idx_r == 2'd2) &
                        instr_r[pot_pkg::INS_WRITE_BIT] &
                        ~instr_r[pot_pkg::INS_SAVED_BIT];
  assign bus_wr_saved = byte_done & (byte_idx_r == 2'd2) &
                        instr_r[pot_pkg::INS_WRITE_BIT] &
                        instr_r[pot_pkg::INS_SAVED_BIT] & wp_s;

  assign rd_val = instr_r[pot_pkg::INS_SAVED_BIT] ?
                  saved_position_reg_r[ins_pot][ins_slot] :
                  wiper_position_reg_r[ins_pot];

  // Recall runs once after reset, before any step can land
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      recall_r <= 1'b1;
    end else begin
      recall_r <= 1'b0;
    end
  end

  genvar gp;
  genvar gs;
  generate
    for (gp = 0; gp < pot_pkg::NUM_POTS; gp++) begin : g_pot
      // Each pot owns one wiper and four saved slots
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          wiper_position_reg_r[gp] <= pot_pkg::WIPER_MIN;
        end else if (recall_r) begin
          wiper_position_reg_r[gp] <= saved_position_reg_r[gp][0];
        end else if (ud_step && (sel_s == 2'(gp))) begin
          if (dir_s && wiper_position_reg_r[gp] != pot_pkg::WIPER_MAX) begin
            wiper_position_reg_r[gp] <= wiper_position_reg_r[gp] + 8'd1;
          end else if (!dir_s &&
                       wiper_position_reg_r[gp] != pot_pkg::WIPER_MIN) begin
            wiper_position_reg_r[gp] <= wiper_position_reg_r[gp] - 8'd1;
          end
        end else if (bus_wr_wiper && (ins_pot == 2'(gp))) begin
          wiper_position_reg_r[gp] <= rx_nxt;
        end
      end

      // Wiper value is the tap index, 0 to 255
      assign wiper_pos_o[gp*8 +: 8] = wiper_position_reg_r[gp];

      for (gs = 0; gs < pot_pkg::NUM_SAVED; gs++) begin : g_slot
        // Reset stands in for the stored content a real part keeps
        always_ff @(posedge core_clk_i) begin
          if (reset_i) begin
            saved_position_reg_r[gp][gs] <= pot_pkg::SAVED_DEFAULT;
          end else if (bus_wr_saved && ins_pot == 2'(gp) &&
                       ins_slot == 2'(gs)) begin
            saved_position_reg_r[gp][gs] <= rx_nxt;
          end else if (ud_store && gs == 0 && sel_s == 2'(gp)) begin
            saved_position_reg_r[gp][gs] <= wiper_position_reg_r[gp];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (reset_i || !cs_s || bus_stop) begin
      state_r     <= pot_pkg::DS_IDLE;
      drive_low_r <= 1'b0;
      bit_cnt_r   <= 3'd0;
      byte_idx_r  <= 2'd0;
      ack_phase_r <= 1'b0;
      ack_ok_r    <= 1'b0;
      rx_r        <= 8'h00;
      tx_r        <= 8'h00;
      instr_r     <= 8'h00;
    end else if (bus_start) begin
      state_r     <= pot_pkg::DS_RECV;
      drive_low_r <= 1'b0;
      bit_cnt_r   <= 3'd0;
      byte_idx_r  <= 2'd0;
    end else begin
      case (state_r)
        pot_pkg::DS_RECV: begin
          if (scl_rise) begin
            rx_r        <= rx_nxt;
            bit_cnt_r   <= bit_cnt_r + 3'd1;
            ack_phase_r <= 1'b0;
            if (bit_cnt_r == 3'd7) begin
              if (byte_idx_r == 2'd0) begin
                // Foreign address: stay off the line
                if (rx_nxt == {pot_pkg::ADDR_FIXED, strap_s}) begin
                  state_r  <= pot_pkg::DS_ACK;
                  ack_ok_r <= 1'b1;
                end else begin
                  state_r <= pot_pkg::DS_IGNORE;
                end
              end else if (byte_idx_r == 2'd1) begin
                instr_r  <= rx_nxt;
                ack_ok_r <= 1'b1;
                state_r  <= pot_pkg::DS_ACK;
              end else begin
                // Refused saved write is answered with no acknowledge
                ack_ok_r <= ~(instr_r[pot_pkg::INS_SAVED_BIT] &
                              instr_r[pot_pkg::INS_WRITE_BIT] & ~wp_s);
                state_r  <= pot_pkg::DS_ACK;
              end
            end
          end
        end
        pot_pkg::DS_ACK: begin
          if (scl_fall) begin
            if (!ack_phase_r) begin
              drive_low_r <= ack_ok_r;
              ack_phase_r <= 1'b1;
            end else begin
              byte_idx_r <= byte_idx_r + 2'd1;
              bit_cnt_r  <= 3'd0;
              if (byte_idx_r == 2'd1 && !instr_r[pot_pkg::INS_WRITE_BIT]) begin
                tx_r        <= rd_val;
                drive_low_r <= ~rd_val[7];
                state_r     <= pot_pkg::DS_SEND;
              end else if (byte_idx_r == 2'd2) begin
                drive_low_r <= 1'b0;
                state_r     <= pot_pkg::DS_IGNORE;
              end else begin
                drive_low_r <= 1'b0;
                state_r     <= pot_pkg::DS_RECV;
              end
            end
          end
        end
        pot_pkg::DS_SEND: begin
          if (scl_fall) begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7) begin
              drive_low_r <= 1'b0;
              state_r     <= pot_pkg::DS_IGNORE;
            end else begin
              tx_r        <= {tx_r[6:0], 1'b0};
              drive_low_r <= ~tx_r[6];
            end
          end
        end
        pot_pkg::DS_IGNORE: begin
          drive_low_r <= 1'b0;
        end
        default: begin
          drive_low_r <= 1'b0;
        end
      endcase
    end
  end

  // Only ever pull low or let go
  assign link.sda_dev_o    = 1'b0;
  assign link.sda_dev_oe_n = ~drive_low_r;

endmodule // pot_device

`default_nettype wire

// >>> verilog/pot_pkg.sv
`default_nettype none

package pot_pkg;

  localparam int unsigned NUM_POTS      = 4;
  localparam int unsigned NUM_SAVED     = 4;
  localparam int unsigned POS_W         = 8;
  localparam int unsigned FRAME_BITS    = 27;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SCL_PERIOD_NS = 10000;
  localparam int unsigned LINK_QTR_CYCLES =
    SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  localparam logic [4:0] ADDR_FIXED     = 5'h15;
  localparam logic [7:0] SAVED_DEFAULT  = 8'h80;
  localparam logic [7:0] WIPER_MIN      = 8'h00;
  localparam logic [7:0] WIPER_MAX      = 8'hFF;

  // Instruction byte: [7] saved, [6] write, [5:4] pot, [3:2] slot
  localparam int unsigned INS_SAVED_BIT = 7;
  localparam int unsigned INS_WRITE_BIT = 6;
  localparam int unsigned INS_POT_LSB   = 4;
  localparam int unsigned INS_SLOT_LSB  = 2;

  typedef enum logic [2:0] {
    DS_IDLE   = 3'b000,
    DS_RECV   = 3'b001,
    DS_ACK    = 3'b010,
    DS_SEND   = 3'b011,
    DS_IGNORE = 3'b100
  } dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_START = 3'b001,
    HS_BIT   = 3'b010,
    HS_STOP  = 3'b011,
    HS_STEP  = 3'b100
  } host_state_t;

  typedef enum logic [2:0] {
    OP_RD_WIPER = 3'b000,
    OP_WR_WIPER = 3'b001,
    OP_RD_SAVED = 3'b010,
    OP_WR_SAVED = 3'b011,
    OP_STEP     = 3'b100,
    OP_STORE    = 3'b101
  } host_op_t;

endpackage

`default_nettype wire

// >>> verilog/pot_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pot_link_if;
  logic scl;
  logic cs_n;
  logic dir_up;
  logic pot_selector_lo;
  logic pot_selector_hi;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda;

  // Open-drain wire with pull-up: low when any enabled driver pulls low
  assign sda = (sda_dev_oe_n | sda_dev_o) & (sda_host_oe_n | sda_host_o);

  modport device (
    input  scl, cs_n, dir_up, pot_selector_lo, pot_selector_hi, sda,
    output sda_dev_o, sda_dev_oe_n
  );

  modport host (
    output scl, cs_n, dir_up, pot_selector_lo, pot_selector_hi,
    output sda_host_o, sda_host_oe_n,
    input  sda
  );
endinterface

`default_nettype wire

// >>> verilog/pot_host.sv
`timescale 1ns/1ps
`default_nettype none

module pot_host #(
  parameter int unsigned QTR_CYCLES = pot_pkg::LINK_QTR_CYCLES
) (
  input  wire logic                core_clk_i,
  input  wire logic                reset_i,
  pot_link_if.host                 link,
  input  wire logic                cmd_valid_i,
  output logic                     cmd_ready_o,
  input  wire pot_pkg::host_op_t   cmd_op_i,
  input  wire logic [1:0]          cmd_pot_i,
  input  wire logic [1:0]          cmd_slot_i,
  input  wire logic [7:0]          cmd_data_i,
  input  wire logic                cmd_up_i,
  input  wire logic [2:0]          dev_addr_i,
  output logic                     done_o,
  output logic                     ack_ok_o,
  output logic [7:0]               rd_data_o
);

  pot_pkg::host_state_t state_r;
  pot_pkg::host_op_t    op_r;
  logic [15:0]          tick_cnt_r;
  logic                 tick;
  logic [1:0]           q_r;
  logic [4:0]           slot_r;
  logic [26:0]          frame_r;
  logic [26:0]          rx_r;
  logic                 scl_r;
  logic                 sda_low_r;
  logic                 cs_n_r;
  logic                 dir_r;
  logic [1:0]           sel_r;
  logic                 sda_m_r;
  logic                 sda_s_r;
  logic                 is_read;
  logic [7:0]           instr;

  assign tick        = (tick_cnt_r == 16'(QTR_CYCLES - 1));
  assign cmd_ready_o = (state_r == pot_pkg::HS_IDLE);
  assign is_read     = ~op_r[0];
  assign instr       = {cmd_op_i[1], cmd_op_i[0], cmd_pot_i, cmd_slot_i,
                        2'b00};

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
    end
  end

  // Link clock made here by dividing the core clock
  always_ff @(posedge core_clk_i) begin
    if (reset_i || state_r == pot_pkg::HS_IDLE || tick) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r   <= pot_pkg::HS_IDLE;
      op_r      <= pot_pkg::OP_RD_WIPER;
      q_r       <= 2'd0;
      slot_r    <= 5'd0;
      frame_r   <= '0;
      rx_r      <= '0;
      scl_r     <= 1'b1;
      sda_low_r <= 1'b0;
      cs_n_r    <= 1'b1;
      dir_r     <= 1'b0;
      sel_r     <= 2'd0;
      done_o    <= 1'b0;
      ack_ok_o  <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        pot_pkg::HS_IDLE: begin
          q_r    <= 2'd0;
          slot_r <= 5'd0;
          if (cmd_valid_i) begin
            op_r  <= cmd_op_i;
            sel_r <= cmd_pot_i;
            dir_r <= cmd_up_i;
            if (cmd_op_i == pot_pkg::OP_STEP ||
                cmd_op_i == pot_pkg::OP_STORE) begin
              state_r <= pot_pkg::HS_STEP;
            end else begin
              frame_r <= {pot_pkg::ADDR_FIXED, dev_addr_i, 1'b1, instr,
                          1'b1, (cmd_op_i[0] ? cmd_data_i : 8'hFF), 1'b1};
              state_r <= pot_pkg::HS_START;
            end
          end
        end
        pot_pkg::HS_START: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            if (q_r == 2'd0) begin
              sda_low_r <= 1'b1;
            end else begin
              scl_r   <= 1'b0;
              q_r     <= 2'd0;
              state_r <= pot_pkg::HS_BIT;
            end
          end
        end
        pot_pkg::HS_BIT: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            case (q_r)
              2'd0: sda_low_r <= ~frame_r[26];
              2'd1: scl_r <= 1'b1;
              2'd2: rx_r <= {rx_r[25:0], sda_s_r};
              default: begin
                scl_r   <= 1'b0;
                frame_r <= {frame_r[25:0], 1'b1};
                slot_r  <= slot_r + 5'd1;
                if (slot_r == 5'(pot_pkg::FRAME_BITS - 1)) begin
                  state_r <= pot_pkg::HS_STOP;
                end
              end
            endcase
          end
        end
        pot_pkg::HS_STOP: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            case (q_r)
              2'd0: sda_low_r <= 1'b1;
              2'd1: scl_r <= 1'b1;
              2'd2: sda_low_r <= 1'b0;
              default: begin
                done_o    <= 1'b1;
                ack_ok_o  <= ~rx_r[18] & ~rx_r[9] & (is_read | ~rx_r[0]);
                rd_data_o <= rx_r[8:1];
                state_r   <= pot_pkg::HS_IDLE;
              end
            endcase
          end
        end
        pot_pkg::HS_STEP: begin
          // Step: clock low before select is released, so no store fires
          if (tick) begin
            slot_r <= slot_r + 5'd1;
            case (slot_r)
              5'd0: scl_r <= (op_r == pot_pkg::OP_STORE);
              5'd1: cs_n_r <= 1'b0;
              5'd2: scl_r <= 1'b1;
              5'd3: scl_r <= (op_r == pot_pkg::OP_STORE);
              5'd4: cs_n_r <= 1'b1;
              default: begin
                scl_r    <= 1'b1;
                done_o   <= 1'b1;
                ack_ok_o <= 1'b1;
                state_r  <= pot_pkg::HS_IDLE;
              end
            endcase
          end
        end
        default: state_r <= pot_pkg::HS_IDLE;
      endcase
    end
  end

  assign link.scl             = scl_r;
  assign link.cs_n            = cs_n_r;
  assign link.dir_up          = dir_r;
  assign link.pot_selector_lo = sel_r[0];
  assign link.pot_selector_hi = sel_r[1];
  assign link.sda_host_o      = 1'b0;
  assign link.sda_host_oe_n   = ~sda_low_r;

endmodule // pot_host

`default_nettype wire

// >>> verification/pot_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module pot_link_monitor #(
  parameter int unsigned QTR_CYCLES = pot_pkg::LINK_QTR_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic scl,
  input wire logic cs_n,
  input wire logic dir_up,
  input wire logic pot_selector_lo,
  input wire logic pot_selector_hi,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe_n,
  input wire logic sda_host_o,
  input wire logic sda_host_oe_n,
  input wire logic sda
);
  default clocking mon_cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // Longest legal pull is an ack slot plus eight zero bits; margin added
  localparam logic [15:0] HOLD_MAX = 16'(40 * QTR_CYCLES);
  logic [15:0] low_cnt_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i || sda_dev_oe_n) begin
      low_cnt_r <= 16'h0000;
    end else begin
      low_cnt_r <= low_cnt_r + 16'h0001;
    end
  end

  a_dev_od_low: assert property (sda_dev_o == 1'b0)
    else $error("device data output not held low");
  a_host_od_low: assert property (sda_host_o == 1'b0)
    else $error("host data output not held low");
  a_wire_pulled_low: assert property (!sda_dev_oe_n |-> !sda)
    else $error("data wire high while device pulls");
  a_dev_drive_fall: assert property ($fell(sda_dev_oe_n) |-> !scl)
    else $error("device began driving while clock high");
  a_dev_release_fall: assert property ($rose(sda_dev_oe_n) |-> !scl)
    else $error("device released data while clock high");
  a_dev_hold_bound: assert property (low_cnt_r < HOLD_MAX)
    else $error("device held data low too long");
  a_dev_quiet_ud: assert property ((!cs_n) [*8] |-> sda_dev_oe_n)
    else $error("device drives data in up/down mode");
  a_host_quiet_ud: assert property (!cs_n |-> sda_host_oe_n)
    else $error("host drives data in up/down mode");
  a_step_inputs_hold: assert property ($rose(scl) && !cs_n |->
      $stable(dir_up) && $stable({pot_selector_hi, pot_selector_lo}))
    else $error("direction or selector moved at step edge");
endmodule // pot_link_monitor

`default_nettype wire

// >>> verification/quad_digital_pot_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module quad_digital_pot_control_tb;
  localparam int unsigned QTR = 8;
  logic              core_clk_i = 1'b0;
  logic              reset_i    = 1'b1;
  logic              cmd_valid  = 1'b0;
  logic              cmd_ready;
  pot_pkg::host_op_t cmd_op     = pot_pkg::OP_RD_WIPER;
  logic [1:0]        cmd_pot    = 2'h0;
  logic [1:0]        cmd_slot   = 2'h0;
  logic [7:0]        cmd_data   = 8'h00;
  logic              cmd_up     = 1'b0;
  logic [2:0]        dev_addr   = 3'h0;
  logic [2:0]        strap      = 3'h0;
  logic              guard      = 1'b1;
  logic              done;
  logic              ack_ok;
  logic [7:0]        rd_data;
  logic [31:0]       wiper_pos;
  int                miscompares  = 0;
  int                total_checks = 0;
  int                seed = 68406;
  int                wiper[4];
  int                saved[4][4];

  always #12.5 core_clk_i = ~core_clk_i;

  pot_link_if pot_link_if_i ();

  pot_device pot_device_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .link(pot_link_if_i),
    .strap_addr_bit0_i(strap[0]), .strap_addr_bit1_i(strap[1]),
    .strap_addr_bit2_i(strap[2]), .nv_write_en_i(guard),
    .wiper_pos_o(wiper_pos));

  pot_host #(.QTR_CYCLES(QTR)) pot_host_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .link(pot_link_if_i),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op),
    .cmd_pot_i(cmd_pot), .cmd_slot_i(cmd_slot), .cmd_data_i(cmd_data),
    .cmd_up_i(cmd_up), .dev_addr_i(dev_addr), .done_o(done),
    .ack_ok_o(ack_ok), .rd_data_o(rd_data));

  pot_link_monitor #(.QTR_CYCLES(QTR)) pot_link_monitor_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .scl(pot_link_if_i.scl),
    .cs_n(pot_link_if_i.cs_n), .dir_up(pot_link_if_i.dir_up),
    .pot_selector_lo(pot_link_if_i.pot_selector_lo),
    .pot_selector_hi(pot_link_if_i.pot_selector_hi),
    .sda_dev_o(pot_link_if_i.sda_dev_o),
    .sda_dev_oe_n(pot_link_if_i.sda_dev_oe_n),
    .sda_host_o(pot_link_if_i.sda_host_o),
    .sda_host_oe_n(pot_link_if_i.sda_host_oe_n), .sda(pot_link_if_i.sda));

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] exp_pos();
    return {8'(wiper[3]), 8'(wiper[2]), 8'(wiper[1]), 8'(wiper[0])};
  endfunction

  // Saved contents stand in for nonvolatile data and return to 0x80
  task automatic reset_model();
    for (int p = 0; p < 4; p++) begin
      wiper[p] = 128;
      for (int s = 0; s < 4; s++) saved[p][s] = 128;
    end
  endtask

  task automatic run(input pot_pkg::host_op_t op, input logic [1:0] pot,
                     input logic [1:0] slot, input logic [7:0] data,
                     input logic up, input logic [2:0] addr);
    int   n;
    int   exp_rd;
    logic hit;
    logic exp_ack;
    hit = (addr == strap);
    exp_ack = hit;
    exp_rd = -1;
    case (op)
      pot_pkg::OP_RD_WIPER: exp_rd = wiper[pot];
      pot_pkg::OP_WR_WIPER: if (hit) wiper[pot] = data;
      pot_pkg::OP_RD_SAVED: exp_rd = saved[pot][slot];
      pot_pkg::OP_WR_SAVED: begin
        exp_ack = hit && guard;
        if (exp_ack) saved[pot][slot] = data;
      end
      pot_pkg::OP_STEP: begin
        exp_ack = 1'b1;
        if (up && wiper[pot] < 255) wiper[pot]++;
        if (!up && wiper[pot] > 0) wiper[pot]--;
      end
      default: begin
        exp_ack = 1'b1;
        if (guard) saved[pot][0] = wiper[pot];
      end
    endcase
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cmd_ready, 1'b1);
      summarize();
    end
    cmd_op = op;
    cmd_pot = pot;
    cmd_slot = slot;
    cmd_data = data;
    cmd_up = up;
    dev_addr = addr;
    cmd_valid = 1'b1;
    @(posedge core_clk_i);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, done, 1'b1);
      summarize();
    end else begin
      chk(32'(ack_ok), 32'(exp_ack));
      if (exp_rd >= 0 && hit) chk(32'(rd_data), 32'(exp_rd));
      chk(wiper_pos, exp_pos());
    end
  endtask

  initial begin
    strap = 3'($random(seed));
    reset_model();
    repeat (2) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1;
    chk(wiper_pos, exp_pos());
    for (int p = 0; p < 4; p++) begin
      run(pot_pkg::OP_RD_WIPER, 2'(p), 2'h0, 8'h00, 1'b0, strap);
      run(pot_pkg::OP_WR_WIPER, 2'(p), 2'h0, 8'($random(seed)), 1'b0,
          strap);
      run(pot_pkg::OP_RD_WIPER, 2'(p), 2'h0, 8'h00, 1'b0, strap);
      run(pot_pkg::OP_WR_SAVED, 2'h1, 2'(p), 8'($random(seed)), 1'b0,
          strap);
      run(pot_pkg::OP_RD_SAVED, 2'h1, 2'(p), 8'h00, 1'b0, strap);
    end
    for (int b = 0; b < 3; b++) begin
      run(pot_pkg::OP_WR_WIPER, 2'h2, 2'h0, 8'h5A, 1'b0,
          strap ^ 3'(1 << b));
    end
    run(pot_pkg::OP_RD_SAVED, 2'h1, 2'h2, 8'h00, 1'b0, ~strap);
    guard = 1'b0;
    run(pot_pkg::OP_WR_SAVED, 2'h1, 2'h3, 8'hC3, 1'b0, strap);
    run(pot_pkg::OP_STORE, 2'h1, 2'h0, 8'h00, 1'b0, strap);
    run(pot_pkg::OP_RD_SAVED, 2'h1, 2'h3, 8'h00, 1'b0, strap);
    run(pot_pkg::OP_RD_SAVED, 2'h1, 2'h0, 8'h00, 1'b0, strap);
    guard = 1'b1;
    for (int p = 0; p < 4; p++) begin
      run(pot_pkg::OP_WR_WIPER, 2'(p), 2'h0, 8'hFE, 1'b0, strap);
      repeat (2) run(pot_pkg::OP_STEP, 2'(p), 2'h0, 8'h00, 1'b1,
                     strap);
      run(pot_pkg::OP_WR_WIPER, 2'(p), 2'h0, 8'h01, 1'b0, strap);
      repeat (2) run(pot_pkg::OP_STEP, 2'(p), 2'h0, 8'h00, 1'b0,
                     strap);
      run(pot_pkg::OP_STORE, 2'(p), 2'h0, 8'h00, 1'b0, strap);
      run(pot_pkg::OP_RD_SAVED, 2'(p), 2'h0, 8'h00, 1'b0, strap);
    end
    repeat (12) run(pot_pkg::OP_STEP, 2'($random(seed)), 2'h0, 8'h00,
                    1'($random(seed)), strap);
    reset_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    reset_model();
    repeat (6) @(posedge core_clk_i);
    #1;
    chk(wiper_pos, exp_pos());
    run(pot_pkg::OP_RD_SAVED, 2'h3, 2'h0, 8'h00, 1'b0, strap);
    summarize();
  end
endmodule // quad_digital_pot_control_tb

`default_nettype wire
